//--- rtl/spg_consts.svh
// offsets, field positions and reset values of the trace packet sync generator
`ifndef SPG_CONSTS_SVH
`define SPG_CONSTS_SVH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define SPG_ADR_CTRL 8'h00
`define SPG_ADR_FREQ 8'h04
`define SPG_ADR_PERIOD 8'h08
`define SPG_ADR_STATUS 8'h0C

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define SPG_CTRL_EN 0
`define SPG_CTRL_ESC 1
`define SPG_CTRL_TS 2
`define SPG_STAT_PEND 0
`define SPG_STAT_HIGH 1
`define SPG_STAT_FIRST 2
`define SPG_STAT_MAST_LSB 8
`define SPG_STAT_CH_LSB 16

// ----------------------------------------------------------------------
// reset values and fixed payloads
// ----------------------------------------------------------------------
`define SPG_CTRL_RST 32'h0000_0000
`define SPG_FREQ_RST 32'h0000_0000
`define SPG_PERIOD_RST 32'h0000_0400
`define SPG_VERSION_VAL 8'h03
`define SPG_ERR_PAYLOAD 8'h00
`define SPG_HDR_NIB 6'h02
`define SPG_TS_NIB 6'h10

`endif

//--- rtl/spg_pkg.sv
// types shared by the trace packet sync generator and its bench
package spg_pkg;

  // --------------------------------------------------------------------
  // packet opcodes, sizes and stimulus kinds
  // --------------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_NULL = 4'h0, OP_M8 = 4'h1, OP_MERR = 4'h2, OP_C8 = 4'h3,
    OP_C16 = 4'h4, OP_DATA = 4'h5, OP_FLAG = 4'h6, OP_TRIG = 4'h7,
    OP_GERR = 4'h8, OP_ASYNC = 4'h9, OP_VERSION = 4'hA, OP_FREQ = 4'hB
  } spg_op_t;

  typedef enum logic [2:0] {
    SZ_4 = 3'h0, SZ_8 = 3'h1, SZ_16 = 3'h2, SZ_32 = 3'h3, SZ_64 = 3'h4
  } spg_size_t;

  typedef enum logic [2:0] {
    K_DATA = 3'h0, K_FLAG = 3'h1, K_TRIG = 3'h2, K_MERR = 3'h3, K_GERR = 3'h4
  } spg_kind_t;

  typedef enum logic [8:0] {
    S_IDLE = 9'h001, S_ASYNC = 9'h002, S_VER = 9'h004, S_FREQ = 9'h008,
    S_MAST = 9'h010, S_CHAN = 9'h020, S_BODY = 9'h040, S_MERR = 9'h080,
    S_GERR = 9'h100
  } spg_st_t;

  // --------------------------------------------------------------------
  // carriers
  // --------------------------------------------------------------------
  typedef struct packed {
    logic valid;
    spg_kind_t kind;
    logic [7:0] master;
    logic [15:0] channel;
    spg_size_t size;
    logic marker;
    logic ts;
    logic [63:0] data;
  } spg_stim_t;

  typedef struct packed {
    logic valid;
    spg_op_t op;
    spg_size_t size;
    logic marker;
    logic ts;
    logic [63:0] payload;
    logic [63:0] timestamp;
  } spg_pkt_t;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } spg_wb_req_t;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } spg_wb_rsp_t;

  typedef struct packed {
    spg_st_t st;
    logic [31:0] ctrl;
    logic [31:0] freq;
    logic [31:0] period;
    logic en_d;
    logic pend;
    logic high;
    logic first;
    logic [7:0] act_master;
    logic [15:0] act_ch;
    spg_stim_t cur;
    spg_pkt_t pkt;
    logic stim_rdy;
    logic done;
    logic [31:0] nib_cnt;
    logic odd;
    logic ack;
    logic [31:0] rdat;
    logic ext_s1;
    logic ext_s2;
    logic ext_s3;
    logic ext_f;
  } spg_state_t;

endpackage

//--- rtl/spg_trace_packet_sync_gen.sv
// trace packet generator with alignment synchronization and its register file
//
// Decided for this implementation: the Wishbone slave port and the register offsets.
`timescale 1ns/1ps
`include "spg_consts.svh"

// Notes on behaviour
// (R1) a VERSION packet always follows each ASYNC directly
// (R2) channel packet only on change: C16 if upper byte differs, else C8
// (R3) VERSION clears tracked master and channel to zero
// (R4) data packets of 4 to 64 bits, plain, marker, timestamp, or both
// (R5) M8 only when the source master differs from the tracked one
// (R6) dropped stimulus of one master yields a MERR for it
// (R7) drops from several masters yield one GERR instead
// (R8) FLAG marker packets, with or without timestamp
// (R9) NULL filler may byte-align the stream
// (R10) TRIG and TRIG with timestamp packets
// (R11) VERSION payload is always 3
// (R12) with timestamping on, FREQ follows ASYNC-VERSION directly
// (R13) sync packets come first after enable and on each escalated request
// (R14) sync done output pulses one cycle per synchronization
// (R15) enable, frequency write and period write raise sync requests
// (R16) byte count reaching the period raises a sync request
// (R17) external request line demands a sync at the next opportunity
// (R18) all sync requests ignored while tracing is disabled
// (R19) requests arriving close together merge into one sync
// (R20) a sync that cannot go yet stays pending
// (R21) new request while pending with escalation set raises priority
// (R22) high-priority sync stalls other trace data
// (R23) MERR and GERR carry an 8-bit zero payload
// (R24) MERR of an inactive master gets M8 first; channel cleared after
// (R25) sync clears the period byte counter
// (R26) FREQ payload is the frequency register at sync time
module spg_trace_packet_sync_gen #(
  parameter int ADR_W = 8
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire spg_pkg::spg_wb_req_t wb_req,
  output spg_pkg::spg_wb_rsp_t wb_rsp,
  input wire spg_pkg::spg_stim_t stim_in,
  output logic stim_ready,
  output spg_pkg::spg_pkt_t pkt_out,
  input wire logic pkt_ready,
  input wire logic [63:0] ts_value,
  input wire logic external_sync_request,
  output logic sync_done_pulse
);

  // --------------------------------------------------------------------
  // elaboration check
  // --------------------------------------------------------------------
  generate
    if (ADR_W != 8) begin : g_bad_adr
      $error("spg: ADR_W must be 8");
    end
  endgenerate

  // --------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------
  // one-hot hit {status, period, freq, ctrl}; zero when unmapped
  function automatic logic [3:0] reg_dec(input logic [7:0] adr);
    logic [3:0] h;
    h = 4'h0;
    case (adr)
      `SPG_ADR_CTRL: h = 4'h1;
      `SPG_ADR_FREQ: h = 4'h2;
      `SPG_ADR_PERIOD: h = 4'h4;
      `SPG_ADR_STATUS: h = 4'h8;
      default: h = 4'h0;
    endcase
    return h;
  endfunction

  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d,
                                         input logic [3:0] sel);
    logic [31:0] v;
    v = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        v[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return v;
  endfunction

  function automatic spg_pkg::spg_pkt_t mkpkt(input spg_pkg::spg_op_t op,
                                              input spg_pkg::spg_size_t sz,
                                              input logic mk, input logic ts,
                                              input logic [63:0] pl,
                                              input logic [63:0] tv);
    spg_pkg::spg_pkt_t p;
    p.valid = 1'b1;
    p.op = op;
    p.size = sz;
    p.marker = mk;
    p.ts = ts;
    p.payload = pl;
    p.timestamp = ts ? tv : 64'h0;
    return p;
  endfunction

  // nibble length: header plus payload plus optional timestamp
  function automatic logic [5:0] pkt_nib(input spg_pkg::spg_pkt_t p);
    logic [5:0] n;
    n = `SPG_HDR_NIB;
    case (p.op)
      spg_pkg::OP_NULL: n = 6'h01;
      spg_pkg::OP_M8, spg_pkg::OP_MERR, spg_pkg::OP_GERR,
      spg_pkg::OP_C8, spg_pkg::OP_VERSION: n = `SPG_HDR_NIB + 6'h02;
      spg_pkg::OP_C16: n = `SPG_HDR_NIB + 6'h04;
      spg_pkg::OP_FREQ: n = `SPG_HDR_NIB + 6'h08;
      spg_pkg::OP_DATA: n = `SPG_HDR_NIB + (6'h01 << p.size);
      default: n = `SPG_HDR_NIB;
    endcase
    if (p.ts) begin
      n = n + `SPG_TS_NIB;
    end
    return n;
  endfunction

  // --------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------
  spg_pkg::spg_state_t r;
  spg_pkg::spg_state_t n;

  logic [3:0] hit;
  logic bus_go;
  logic freq_wr;
  logic per_wr;
  logic en;
  logic en_rise;
  logic ts_en;
  logic ext_rise;
  logic per_hit;
  logic req;
  logic out_free;
  logic emit;
  logic sync_go;
  spg_pkg::spg_pkt_t ep;
  logic [5:0] nib;

  always_comb begin
    n = r;
    n.done = 1'b0;
    n.ack = 1'b0;
    emit = 1'b0;
    sync_go = 1'b0;
    ep = r.pkt;
    nib = 6'h00;

    // ------------------------------------------------------------------
    // wishbone slave: one wait cycle, ack for one cycle
    // ------------------------------------------------------------------
    hit = reg_dec(wb_req.adr);
    bus_go = wb_req.cyc && wb_req.stb && !r.ack;
    freq_wr = bus_go && wb_req.we && hit[1];
    per_wr = bus_go && wb_req.we && hit[2];
    if (bus_go) begin
      n.ack = 1'b1;
      n.rdat = 32'h0;
      if (wb_req.we) begin
        if (hit[0]) begin
          n.ctrl = wmerge(r.ctrl, wb_req.dat, wb_req.sel) & 32'h0000_0007;
        end
        if (hit[1]) begin
          n.freq = wmerge(r.freq, wb_req.dat, wb_req.sel);
        end
        if (hit[2]) begin
          n.period = wmerge(r.period, wb_req.dat, wb_req.sel);
        end
      end else begin
        case (1'b1)
          hit[0]: n.rdat = r.ctrl;
          hit[1]: n.rdat = r.freq;
          hit[2]: n.rdat = r.period;
          hit[3]: begin
            n.rdat[`SPG_STAT_PEND] = r.pend;
            n.rdat[`SPG_STAT_HIGH] = r.high;
            n.rdat[`SPG_STAT_FIRST] = r.first;
            n.rdat[`SPG_STAT_MAST_LSB +: 8] = r.act_master;
            n.rdat[`SPG_STAT_CH_LSB +: 16] = r.act_ch;
          end
          default: n.rdat = 32'h0;
        endcase
      end
    end

    // ------------------------------------------------------------------
    // external request: three flops, counts once 2nd and 3rd agree
    // ------------------------------------------------------------------
    n.ext_s1 = external_sync_request;
    n.ext_s2 = r.ext_s1;
    n.ext_s3 = r.ext_s2;
    if (r.ext_s2 == r.ext_s3) begin
      n.ext_f = r.ext_s3;
    end
    ext_rise = (r.ext_s2 == r.ext_s3) && r.ext_s3 && !r.ext_f; // see (R17)

    en = r.ctrl[`SPG_CTRL_EN];
    ts_en = r.ctrl[`SPG_CTRL_TS];
    en_rise = en && !r.en_d;
    n.en_d = en;
    // fires once per period; stays quiet while a sync is already pending
    per_hit = (r.period != 32'h0) && ({1'b0, r.nib_cnt[31:1]} >= r.period)
              && !r.pend; // see (R16)

    out_free = !r.pkt.valid || pkt_ready;
    if (out_free) begin
      n.pkt.valid = 1'b0;
    end

    // ------------------------------------------------------------------
    // packet sequencer
    // ------------------------------------------------------------------
    case (r.st)
      spg_pkg::S_IDLE: begin
        if (r.stim_rdy && stim_in.valid) begin
          n.cur = stim_in;
          n.st = (stim_in.kind == spg_pkg::K_GERR) ? spg_pkg::S_GERR : spg_pkg::S_MAST;
        end else if (en && r.pend && out_free
                     && (r.high || r.first || !stim_in.valid)) begin // see (R20) (R22)
          sync_go = 1'b1; // see (R13)
          n.st = spg_pkg::S_VER;
        end else if (!en && r.odd && out_free) begin
          // pad to a byte once tracing stops
          emit = 1'b1;
          ep = mkpkt(spg_pkg::OP_NULL, spg_pkg::SZ_4, 1'b0, 1'b0, 64'h0, ts_value); // see (R9)
        end
      end
      spg_pkg::S_VER: begin
        if (out_free) begin
          emit = 1'b1;
          ep = mkpkt(spg_pkg::OP_VERSION, spg_pkg::SZ_8, 1'b0, 1'b0,
                     {56'h0, `SPG_VERSION_VAL}, ts_value); // see (R1) (R11)
          n.act_master = 8'h00; // see (R3)
          n.act_ch = 16'h0000; // see (R3)
          n.st = ts_en ? spg_pkg::S_FREQ : spg_pkg::S_IDLE;
        end
      end
      spg_pkg::S_FREQ: begin
        if (out_free) begin
          emit = 1'b1;
          ep = mkpkt(spg_pkg::OP_FREQ, spg_pkg::SZ_32, 1'b0, 1'b0,
                     {32'h0, r.freq}, ts_value); // see (R12) (R26)
          n.st = spg_pkg::S_IDLE;
        end
      end
      spg_pkg::S_MAST: begin
        if (out_free) begin
          if (r.cur.master != r.act_master) begin
            emit = 1'b1;
            ep = mkpkt(spg_pkg::OP_M8, spg_pkg::SZ_8, 1'b0, 1'b0,
                       {56'h0, r.cur.master}, ts_value); // see (R5) (R24)
            n.act_master = r.cur.master;
          end
          n.st = (r.cur.kind == spg_pkg::K_MERR) ? spg_pkg::S_MERR : spg_pkg::S_CHAN;
        end
      end
      spg_pkg::S_CHAN: begin
        if (out_free) begin
          if (r.cur.channel != r.act_ch) begin
            emit = 1'b1;
            if (r.cur.channel[15:8] != r.act_ch[15:8]) begin
              ep = mkpkt(spg_pkg::OP_C16, spg_pkg::SZ_16, 1'b0, 1'b0,
                         {48'h0, r.cur.channel}, ts_value); // see (R2)
            end else begin
              ep = mkpkt(spg_pkg::OP_C8, spg_pkg::SZ_8, 1'b0, 1'b0,
                         {56'h0, r.cur.channel[7:0]}, ts_value); // see (R2)
            end
            n.act_ch = r.cur.channel;
          end
          n.st = spg_pkg::S_BODY;
        end
      end
      spg_pkg::S_BODY: begin
        if (out_free) begin
          emit = 1'b1;
          case (r.cur.kind)
            spg_pkg::K_FLAG: ep = mkpkt(spg_pkg::OP_FLAG, spg_pkg::SZ_4, 1'b0,
                                        r.cur.ts && ts_en, 64'h0, ts_value); // see (R8)
            spg_pkg::K_TRIG: ep = mkpkt(spg_pkg::OP_TRIG, spg_pkg::SZ_8, 1'b0,
                                        r.cur.ts && ts_en,
                                        {56'h0, r.cur.data[7:0]}, ts_value); // see (R10)
            default: ep = mkpkt(spg_pkg::OP_DATA, r.cur.size, r.cur.marker,
                                r.cur.ts && ts_en, r.cur.data, ts_value); // see (R4)
          endcase
          n.st = spg_pkg::S_IDLE;
        end
      end
      spg_pkg::S_MERR: begin
        if (out_free) begin
          emit = 1'b1;
          ep = mkpkt(spg_pkg::OP_MERR, spg_pkg::SZ_8, 1'b0, 1'b0,
                     {56'h0, `SPG_ERR_PAYLOAD}, ts_value); // see (R6) (R23)
          n.act_ch = 16'h0000; // see (R24)
          n.st = spg_pkg::S_IDLE;
        end
      end
      spg_pkg::S_GERR: begin
        if (out_free) begin
          emit = 1'b1;
          ep = mkpkt(spg_pkg::OP_GERR, spg_pkg::SZ_8, 1'b0, 1'b0,
                     {56'h0, `SPG_ERR_PAYLOAD}, ts_value); // see (R7) (R23)
          n.st = spg_pkg::S_IDLE;
        end
      end
      default: n.st = spg_pkg::S_IDLE;
    endcase

    if (sync_go) begin
      emit = 1'b1;
      ep = mkpkt(spg_pkg::OP_ASYNC, spg_pkg::SZ_4, 1'b0, 1'b0, 64'h0, ts_value);
      n.done = 1'b1; // see (R14)
      n.pend = 1'b0;
      n.high = 1'b0;
      n.first = 1'b0;
    end

    // ------------------------------------------------------------------
    // output register and byte accounting
    // ------------------------------------------------------------------
    if (emit) begin
      n.pkt = ep;
      nib = pkt_nib(ep);
      n.nib_cnt = r.nib_cnt + {26'h0, nib};
      n.odd = r.odd ^ nib[0];
    end
    if (sync_go) begin
      n.nib_cnt = 32'h0; // see (R25)
    end

    // ------------------------------------------------------------------
    // sync requests: applied after the clear so a new one is never lost
    // ------------------------------------------------------------------
    req = en_rise || freq_wr || per_wr || per_hit || ext_rise; // see (R15) (R16) (R17)
    if (!en) begin
      n.pend = 1'b0; // see (R18)
      n.high = 1'b0;
      n.first = 1'b0;
    end else if (req) begin
      // a held request is merged, not queued
      if (r.pend && !sync_go && r.ctrl[`SPG_CTRL_ESC]) begin
        n.high = 1'b1; // see (R21)
      end
      n.pend = 1'b1; // see (R19)
      if (en_rise) begin
        n.first = 1'b1; // see (R13)
      end
    end

    // stimulus waits while a forced sync is due
    n.stim_rdy = (n.st == spg_pkg::S_IDLE) && en && !n.first && !n.high; // see (R22)
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      r <= '0;
      r.st <= spg_pkg::S_IDLE;
      r.ctrl <= `SPG_CTRL_RST;
      r.freq <= `SPG_FREQ_RST;
      r.period <= `SPG_PERIOD_RST;
    end else begin
      r <= n;
    end
  end

  // --------------------------------------------------------------------
  // outputs, all straight from the state register
  // --------------------------------------------------------------------
  assign wb_rsp.ack = r.ack;
  assign wb_rsp.dat = r.rdat;
  assign stim_ready = r.stim_rdy;
  assign pkt_out = r.pkt;
  assign sync_done_pulse = r.done;

endmodule // spg_trace_packet_sync_gen

//--- tb/spg_chk_sva.sv
// port checks of the trace packet sync generator
`timescale 1ns/1ps
module spg_chk (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire spg_pkg::spg_wb_req_t wb_req,
  input wire spg_pkg::spg_wb_rsp_t wb_rsp,
  input wire logic stim_ready,
  input wire spg_pkg::spg_pkt_t pkt_out,
  input wire logic pkt_ready,
  input wire logic sync_done_pulse
);
  logic wr0, take, en_r, ts_r, first_r;
  spg_pkg::spg_op_t last_r;
  assign wr0 = wb_req.cyc && wb_req.stb && wb_req.we && !wb_rsp.ack
    && wb_req.adr == 8'h00 && wb_req.sel[0];
  assign take = pkt_out.valid && pkt_ready;
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      en_r <= 1'b0;
      ts_r <= 1'b0;
      first_r <= 1'b0;
      last_r <= spg_pkg::OP_NULL;
    end else begin
      if (wr0) en_r <= wb_req.dat[0];
      if (wr0) ts_r <= wb_req.dat[2];
      // a stray filler may still drain before the first sync
      if (wr0 && wb_req.dat[0] && !en_r) first_r <= 1'b1;
      else if (take && pkt_out.op != spg_pkg::OP_NULL) first_r <= 1'b0;
      if (take) last_r <= pkt_out.op;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  sequence s_req;
    wb_req.cyc && wb_req.stb && !wb_rsp.ack;
  endsequence
  sequence s_ack1;
    wb_rsp.ack ##1 !wb_rsp.ack;
  endsequence
  a_bus_ack_once: assert property (s_req |=> s_ack1)
    else $error("bus ack missing or too long");
  a_done_async: assert property (
    sync_done_pulse |-> pkt_out.valid && pkt_out.op == spg_pkg::OP_ASYNC)
    else $error("sync pulse without alignment packet");
  a_done_single: assert property (sync_done_pulse |=> !sync_done_pulse)
    else $error("sync pulse longer than one cycle");
  a_ver_follows: assert property (
    take && last_r == spg_pkg::OP_ASYNC |-> pkt_out.op == spg_pkg::OP_VERSION)
    else $error("version does not follow alignment");
  a_freq_follows: assert property (
    take && ts_r && last_r == spg_pkg::OP_VERSION |-> pkt_out.op == spg_pkg::OP_FREQ)
    else $error("frequency does not follow version");
  a_ver_value: assert property (
    pkt_out.valid && pkt_out.op == spg_pkg::OP_VERSION |-> pkt_out.payload == 64'h3)
    else $error("version payload wrong");
  a_err_zero: assert property (
    pkt_out.valid && (pkt_out.op == spg_pkg::OP_MERR || pkt_out.op == spg_pkg::OP_GERR)
    |-> pkt_out.payload == 64'h0)
    else $error("error payload not zero");
  a_first_async: assert property (
    take && first_r && pkt_out.op != spg_pkg::OP_NULL |-> pkt_out.op == spg_pkg::OP_ASYNC)
    else $error("first packet after enable not alignment");
  a_off_quiet: assert property (
    !en_r && !$past(en_r) && !$past(en_r, 2) |-> !sync_done_pulse && !stim_ready)
    else $error("activity while disabled");
  a_hold_out: assert property (pkt_out.valid && !pkt_ready |=> $stable(pkt_out))
    else $error("packet changed while stalled");
endmodule // spg_chk
bind spg_trace_packet_sync_gen spg_chk u_chk (.clk_sys, .sys_rst, .wb_req, .wb_rsp,
  .stim_ready, .pkt_out, .pkt_ready, .sync_done_pulse);

//--- tb/spg_sink.sv
// trace sink partner: takes packets promptly, every other cycle, or stalls
`timescale 1ns/1ps
module spg_sink (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire spg_pkg::spg_pkt_t pkt_out,
  input wire logic stall,
  input wire logic slow,
  output logic pkt_ready
);
  spg_pkg::spg_pkt_t log_q[$];
  logic tog_r;
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      tog_r <= 1'b0;
      log_q.delete();
    end else begin
      tog_r <= ~tog_r;
      if (pkt_out.valid && pkt_ready) log_q.push_back(pkt_out);
    end
  end
  // ready only moves with registered state, never mid-cycle
  assign pkt_ready = !stall && (!slow || tog_r);
endmodule // spg_sink

//--- tb/tb.sv
// self-checking bench for the trace packet sync generator
`timescale 1ns/1ps
module tb;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  spg_pkg::spg_wb_req_t wb_req = '0;
  spg_pkg::spg_wb_rsp_t wb_rsp;
  spg_pkg::spg_stim_t stim_in = '0;
  spg_pkg::spg_pkt_t pkt_out;
  spg_pkg::spg_pkt_t pk;
  logic stim_ready, pkt_ready, sync_done_pulse;
  logic ext_req = 1'b0;
  logic stall = 1'b0;
  logic [63:0] ts_value = 64'h0;
  logic [31:0] rd;
  int err_total = 0;
  int n_checks = 0;
  int n_sync = 0;
  int cyc_n = 0;
  always #25 clk_sys = ~clk_sys;
  spg_trace_packet_sync_gen dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .wb_req(wb_req),
    .wb_rsp(wb_rsp), .stim_in(stim_in), .stim_ready(stim_ready), .pkt_out(pkt_out),
    .pkt_ready(pkt_ready), .ts_value(ts_value), .external_sync_request(ext_req),
    .sync_done_pulse(sync_done_pulse));
  spg_sink u_sink (.clk_sys(clk_sys), .sys_rst(sys_rst), .pkt_out(pkt_out), .stall(stall),
    .slow(1'b1), .pkt_ready(pkt_ready));
  task automatic test_done();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc_n <= cyc_n + 1;
    ts_value <= ts_value + 64'h1;
    if (sync_done_pulse === 1'b1) n_sync <= n_sync + 1;
    if (cyc_n == 20000) begin
      err_total = err_total + 1;
      test_done();
    end
  end
  task automatic chk_op(spg_pkg::spg_op_t got, spg_pkg::spg_op_t exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t op %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic chk_w(logic [63:0] got, logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t value %0h expected %0h", $time, got, exp);
    end
  endtask
  // ---------------------------------------------------------------
  // bus and stimulus drivers
  // ---------------------------------------------------------------
  task automatic wb(logic we, logic [7:0] adr, logic [31:0] dat);
    @(posedge clk_sys);
    wb_req <= '{1'b1, 1'b1, we, adr, 4'hF, dat};
    // only the cycle ceiling may end this wait
    do begin
      @(posedge clk_sys);
    end while (wb_rsp.ack !== 1'b1);
    rd = wb_rsp.dat;
    wb_req <= '0;
  endtask
  task automatic rchk(logic [7:0] adr, logic [31:0] exp);
    wb(1'b0, adr, 32'h0);
    chk_w(64'(rd), 64'(exp));
  endtask
  // releasing the stall here lets a due escalated sync go out ahead of a held stimulus
  task automatic send(spg_pkg::spg_kind_t k, logic [7:0] m, logic [15:0] ch,
      spg_pkg::spg_size_t sz, logic mk, logic t);
    @(posedge clk_sys);
    stim_in <= '{1'b1, k, m, ch, sz, mk, t, 64'hA5};
    stall <= 1'b0;
    do begin
      @(posedge clk_sys);
    end while (stim_ready !== 1'b1);
    stim_in <= '0;
  endtask
  task automatic nxt(spg_pkg::spg_op_t op);
    int i;
    for (i = 0; i < 300; i++) begin
      if (u_sink.log_q.size() > 0) break;
      @(posedge clk_sys);
    end
    pk = '0;
    if (u_sink.log_q.size() > 0) pk = u_sink.log_q.pop_front();
    chk_op(pk.op, op);
  endtask
  task automatic sync_seq(logic [63:0] f);
    nxt(spg_pkg::OP_ASYNC);
    nxt(spg_pkg::OP_VERSION);
    chk_w(pk.payload, 64'h3);
    nxt(spg_pkg::OP_FREQ);
    chk_w(pk.payload, f);
  endtask
  task automatic ext_pulse();
    @(posedge clk_sys);
    ext_req <= 1'b1;
    repeat (4) @(posedge clk_sys);
    ext_req <= 1'b0;
    repeat (4) @(posedge clk_sys);
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_regs();
    rchk(8'h00, 32'h0);
    rchk(8'h08, 32'h0000_0400);
    wb(1'b1, 8'h08, 32'h0);
    wb(1'b1, 8'h10, 32'hFFFF_FFFF);
    rchk(8'h10, 32'h0);
    ext_pulse();
    chk_w(64'(n_sync), 64'h0);
  endtask
  task automatic t_en();
    wb(1'b1, 8'h04, 32'h0131_2D00);
    wb(1'b1, 8'h00, 32'h0000_00FD);
    rchk(8'h00, 32'h5);
    sync_seq(64'h0131_2D00);
    chk_w(64'(n_sync), 64'h1);
  endtask
  task automatic t_stim();
    int i;
    send(spg_pkg::K_DATA, 8'h05, 16'h0012, spg_pkg::SZ_8, 1'b0, 1'b0);
    nxt(spg_pkg::OP_M8);
    nxt(spg_pkg::OP_C8);
    nxt(spg_pkg::OP_DATA);
    send(spg_pkg::K_DATA, 8'h05, 16'h0013, spg_pkg::SZ_8, 1'b0, 1'b0);
    nxt(spg_pkg::OP_C8);
    nxt(spg_pkg::OP_DATA);
    send(spg_pkg::K_DATA, 8'h05, 16'h0113, spg_pkg::SZ_8, 1'b0, 1'b0);
    nxt(spg_pkg::OP_C16);
    nxt(spg_pkg::OP_DATA);
    for (i = 0; i < 20; i++) begin
      send(spg_pkg::K_DATA, 8'h05, 16'h0113, spg_pkg::spg_size_t'(i / 4), i[0], i[1]);
      nxt(spg_pkg::OP_DATA);
      chk_w(64'({pk.size, pk.marker, pk.ts}), 64'({3'(i / 4), i[0], i[1]}));
      chk_w(64'(pk.timestamp != 64'h0), 64'(i[1]));
    end
    for (i = 0; i < 4; i++) begin
      send(i[1] ? spg_pkg::K_TRIG : spg_pkg::K_FLAG, 8'h05, 16'h0113, spg_pkg::SZ_4,
        1'b0, i[0]);
      nxt(i[1] ? spg_pkg::OP_TRIG : spg_pkg::OP_FLAG);
      chk_w(64'(pk.ts), 64'(i[0]));
    end
    send(spg_pkg::K_MERR, 8'h07, 16'h0113, spg_pkg::SZ_8, 1'b0, 1'b0);
    nxt(spg_pkg::OP_M8);
    nxt(spg_pkg::OP_MERR);
    send(spg_pkg::K_DATA, 8'h07, 16'h0113, spg_pkg::SZ_8, 1'b0, 1'b0);
    nxt(spg_pkg::OP_C16);
    nxt(spg_pkg::OP_DATA);
    send(spg_pkg::K_GERR, 8'h05, 16'h0113, spg_pkg::SZ_8, 1'b0, 1'b0);
    nxt(spg_pkg::OP_GERR);
  endtask
  task automatic t_merge();
    wb(1'b1, 8'h00, 32'h7);
    send(spg_pkg::K_DATA, 8'h09, 16'h0113, spg_pkg::SZ_16, 1'b0, 1'b0);
    stall <= 1'b1;
    wb(1'b1, 8'h04, 32'h0000_1000);
    ext_pulse();
    wb(1'b0, 8'h0C, 32'h0);
    chk_w(64'(rd[1:0]), 64'h3);
    send(spg_pkg::K_DATA, 8'h05, 16'h0113, spg_pkg::SZ_8, 1'b0, 1'b0);
    nxt(spg_pkg::OP_M8);
    nxt(spg_pkg::OP_DATA);
    sync_seq(64'h0000_1000);
    nxt(spg_pkg::OP_M8);
    nxt(spg_pkg::OP_C16);
    nxt(spg_pkg::OP_DATA);
    chk_w(64'(n_sync), 64'h2);
  endtask
  task automatic t_ext();
    int i;
    wb(1'b1, 8'h08, 32'h0000_0010);
    for (i = 0; i < 4; i++) send(spg_pkg::K_DATA, 8'h05, 16'h0113, spg_pkg::SZ_64, 1'b0, 1'b0);
    repeat (40) @(posedge clk_sys);
    chk_w(64'(n_sync > 3), 64'h1);
    wb(1'b1, 8'h08, 32'h0);
    repeat (40) @(posedge clk_sys);
    u_sink.log_q.delete();
    i = n_sync;
    ext_pulse();
    sync_seq(64'h0000_1000);
    chk_w(64'(n_sync - i), 64'h1);
  endtask
  task automatic t_off();
    // earlier packets add up to an even nibble count; a short data packet makes it odd
    send(spg_pkg::K_DATA, 8'h05, 16'h0113, spg_pkg::SZ_4, 1'b0, 1'b0);
    nxt(spg_pkg::OP_M8);
    nxt(spg_pkg::OP_C16);
    nxt(spg_pkg::OP_DATA);
    wb(1'b1, 8'h00, 32'h0);
    nxt(spg_pkg::OP_NULL);
    chk_w(64'(pk.valid), 64'h1);
  endtask
  initial begin
    repeat (5) @(posedge clk_sys);
    sys_rst <= 1'b0;
    t_regs();
    t_en();
    t_stim();
    t_merge();
    t_ext();
    t_off();
    test_done();
  end
endmodule // tb
